// [rtl/scp_device.sv]
// device end of the serial control port with program-ram bootload
// assumes link pins asynchronous to core_clk_i; sclk at most core/8
//
`timescale 1ns/1ns
`default_nettype none
module scp_device
    import scp_pkg::*;
#(
    parameter int PRAM_DEPTH_P = PRAM_DEPTH,
    parameter int NREGS = DREG_COUNT
)
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // serial link
    scp_if.device link,
    // core side
    input wire logic [$clog2(PRAM_DEPTH_P)-1:0] pram_raddr_i,
    output logic [7:0] pram_rdata_o,
    input wire logic [5:0] dreg_addr_i,
    output logic [7:0] dreg_rdata_o,
    output logic bootload_active_o,
    output logic program_source_select_o,
    output logic [7:0] load_signature_o
);
    localparam int PA_W = $clog2(PRAM_DEPTH_P);
    localparam logic [PA_W:0] FILL_LIMIT = (PA_W+1)'(PRAM_DEPTH_P);

    typedef struct packed {
        logic [2:0] cs_sync;
        logic [2:0] sclk_sync;
        logic [2:0] io_sync;
        logic [2:0] in_sync;
        logic lsb_first;
        logic [4:0] bit_cnt;
        logic [7:0] rx_sh;
        logic rd_cmd;
        logic [5:0] cmd_addr;
        logic [7:0] tx_sh;
        logic io_o;
        logic io_oe_n;
        logic [7:0] bootload_ram_control;
        logic [7:0] sig;
        logic [PA_W:0] fill_cnt;
        logic [PRAM_DEPTH_P-1:0][7:0] pram;
        logic [NREGS-1:0][7:0] dregs;
        logic [7:0] pram_rdata;
        logic [7:0] dreg_rdata;
    } dev_state_t;

    dev_state_t q;
    dev_state_t d;
    logic cs_hi;
    logic cs_fall;
    logic rise;
    logic fall;
    logic bit_in;
    logic booting;
    logic [7:0] nb;
    logic [7:0] rd_word;
    logic [7:0] w;

    always_comb
    begin
        d = q;
        nb = 8'h00;
        rd_word = 8'h00;
        w = 8'h00;
        // first flop feeds only the second
        d.cs_sync = {q.cs_sync[1:0], link.cs_n};
        d.sclk_sync = {q.sclk_sync[1:0], link.sclk};
        d.io_sync = {q.io_sync[1:0], link.io_line};
        d.in_sync = {q.in_sync[1:0], link.in_line};
        cs_hi = q.cs_sync[1];
        cs_fall = !q.cs_sync[1] && q.cs_sync[2];
        rise = q.sclk_sync[1] && !q.sclk_sync[2];
        fall = !q.sclk_sync[1] && q.sclk_sync[2];
        bit_in = q.lsb_first ? q.io_sync[1] : q.in_sync[1];
        booting = q.bootload_ram_control[BOOT_BIT];

        // read source
        if (booting)
        begin
            rd_word = q.cmd_addr[SIG_SELECT_BIT] ? q.bootload_ram_control : q.sig;
        end
        else if (q.cmd_addr == BRC_ADDR)
        begin
            rd_word = q.bootload_ram_control;
        end
        else if (32'(q.cmd_addr) < NREGS)
        begin
            rd_word = q.dregs[q.cmd_addr];
        end

        if (cs_hi)
        begin
            // held idle until the next select
            d.bit_cnt = 5'h00;
            d.rd_cmd = 1'b0;
            d.io_oe_n = 1'b1;
        end
        else
        begin
            if (cs_fall)
            begin
                d.lsb_first = q.sclk_sync[1];
            end
            if (rise && q.bit_cnt < XFER_LEN)
            begin
                nb = q.lsb_first ? {bit_in, q.rx_sh[7:1]} : {q.rx_sh[6:0], bit_in};
                d.rx_sh = nb;
                d.bit_cnt = q.bit_cnt + 5'h01;
                if (q.bit_cnt == CMD_LEN - 5'h01)
                begin
                    d.rd_cmd = q.lsb_first ? nb[0] : nb[7];
                    d.cmd_addr = nb[6:1];
                end
                // read frames never commit, so receive input is ignored
                if (q.bit_cnt == XFER_LEN - 5'h01 && !q.rd_cmd)
                begin
                    if (q.cmd_addr == BRC_ADDR)
                    begin
                        d.bootload_ram_control = nb & BRC_MASK;
                        if (!nb[BOOT_BIT])
                        begin
                            d.sig = SIG_SEED;
                            d.fill_cnt = '0;
                        end
                    end
                    else if (booting)
                    begin
                        // address field ignored; overflow writes dropped
                        if (q.fill_cnt < FILL_LIMIT)
                        begin
                            d.pram[q.fill_cnt[PA_W-1:0]] = nb;
                            d.fill_cnt = q.fill_cnt + 1'b1;
                            d.sig = sig_step(q.sig, nb);
                        end
                    end
                    else if (32'(q.cmd_addr) < NREGS)
                    begin
                        d.dregs[q.cmd_addr] = nb;
                    end
                end
            end
            if (fall && q.rd_cmd && q.bit_cnt >= CMD_LEN && q.bit_cnt < XFER_LEN)
            begin
                w = (q.bit_cnt == CMD_LEN) ? rd_word : q.tx_sh;
                d.io_o = q.lsb_first ? w[0] : w[7];
                d.tx_sh = q.lsb_first ? {1'b0, w[7:1]} : {w[6:0], 1'b0};
                d.io_oe_n = 1'b0;
            end
        end

        // core side read ports
        d.pram_rdata = q.pram[pram_raddr_i];
        if (dreg_addr_i == BRC_ADDR)
        begin
            d.dreg_rdata = q.bootload_ram_control;
        end
        else if (32'(dreg_addr_i) < NREGS)
        begin
            d.dreg_rdata = q.dregs[dreg_addr_i];
        end
        else
        begin
            d.dreg_rdata = 8'h00;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            q <= '0;
            // select pin idles high; starting low would fake a selected port
            q.cs_sync <= 3'h7;
            q.io_oe_n <= 1'b1;
            q.bootload_ram_control <= BRC_RESET;
            q.sig <= SIG_SEED;
        end
        else
        begin
            q <= d;
        end
    end

    assign link.dev_io_o = q.io_o;
    assign link.dev_io_oe_n = q.io_oe_n;
    assign pram_rdata_o = q.pram_rdata;
    assign dreg_rdata_o = q.dreg_rdata;
    assign bootload_active_o = q.bootload_ram_control[BOOT_BIT];
    assign program_source_select_o = q.bootload_ram_control[SRC_BIT];
    assign load_signature_o = q.sig;

endmodule : scp_device
`default_nettype wire

// [rtl/scp_pkg.sv]
// shared constants and helpers for the serial control port and its host
// assumes a 50 MHz core clock on both ends
package scp_pkg;

    // command/address byte and frame
    localparam logic [5:0] BRC_ADDR = 6'h3f;
    localparam int BOOT_BIT = 2;
    localparam int SRC_BIT = 3;
    localparam int SIG_SELECT_BIT = 5;
    localparam logic [4:0] CMD_LEN = 5'h08;
    localparam logic [4:0] XFER_LEN = 5'h10;

    // bootload control and signature
    localparam logic [7:0] BRC_MASK = 8'h0c;
    localparam logic [7:0] BRC_RESET = 8'h00;
    localparam logic [7:0] SIG_SEED = 8'h00;
    localparam logic [7:0] SIG_POLY = 8'h1d;
    localparam int PRAM_DEPTH = 4096;
    localparam int DREG_COUNT = 63;

    // timing
    localparam int CORE_PERIOD_NS = 20;
    localparam int SCLK_HALF_NS = 80;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS / CORE_PERIOD_NS < 1) ? 1 :
        SCLK_HALF_NS / CORE_PERIOD_NS;

    // host command registers
    localparam logic [2:0] HOST_CMD = 3'h0;
    localparam logic [2:0] HOST_ADDR = 3'h1;
    localparam logic [2:0] HOST_WDATA = 3'h2;
    localparam logic [2:0] HOST_RDATA = 3'h3;
    localparam logic [2:0] HOST_STATUS = 3'h4;
    localparam int CMD_RW_BIT = 0;
    localparam int CMD_LSB_BIT = 1;

    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_PREP = 4'b0010,
        H_SHIFT = 4'b0100,
        H_END = 4'b1000
    } host_state_t;

    function automatic logic [7:0] sig_step(input logic [7:0] s, input logic [7:0] din);
        sig_step = {s[6:0], 1'b0} ^ (s[7] ? SIG_POLY : 8'h00) ^ din;
    endfunction : sig_step

    function automatic logic [7:0] rev8(input logic [7:0] v);
        for (int i = 0; i < 8; i++)
        begin
            rev8[i] = v[7-i];
        end
    endfunction : rev8

    function automatic logic [15:0] rev16(input logic [15:0] v);
        for (int i = 0; i < 16; i++)
        begin
            rev16[i] = v[15-i];
        end
    endfunction : rev16

endpackage : scp_pkg

// [rtl/scp_if.sv]
// the four-wire serial link between host and device
// assumes the bench instantiates it; an undriven io line reads high (pull-up)
`timescale 1ns/1ns
`default_nettype none
interface scp_if;
    logic cs_n;
    logic sclk;
    logic in_line;
    logic dev_io_o;
    logic dev_io_oe_n;
    logic host_io_o;
    logic host_io_oe_n;
    logic io_line;

    assign io_line = !dev_io_oe_n ? dev_io_o : (!host_io_oe_n ? host_io_o : 1'b1);

    modport device (
        input cs_n,
        input sclk,
        input in_line,
        input io_line,
        output dev_io_o,
        output dev_io_oe_n
    );

    modport host (
        output cs_n,
        output sclk,
        output in_line,
        output host_io_o,
        output host_io_oe_n,
        input io_line
    );
endinterface : scp_if
`default_nettype wire

// [rtl/scp_host.sv]
// host end: runs one two-byte frame per command written by software
// assumes software orders frames; sclk made here by dividing core_clk_i
`timescale 1ns/1ns
`default_nettype none
module scp_host
    import scp_pkg::*;
#(
    parameter int HALF_P = SCLK_HALF_CYC
)
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [2:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic busy_o,
    // serial link
    scp_if.host link
);
    localparam logic [7:0] DIV_LAST = 8'(HALF_P - 1);

    typedef struct packed {
        logic [1:0] io_sync;
        host_state_t state;
        logic [7:0] div;
        logic sclk;
        logic cs_n;
        logic io_o;
        logic io_oe_n;
        logic din;
        logic lsb;
        logic rw;
        logic [4:0] rise_cnt;
        logic [15:0] seq;
        logic [7:0] rx;
        logic [5:0] addr;
        logic [7:0] wdata;
        logic [7:0] result;
        logic [7:0] bus_rdata;
        logic busy;
    } host_q_t;

    host_q_t q;
    host_q_t d;
    logic tick;
    logic launch;
    logic [4:0] launch_idx;

    always_comb
    begin
        d = q;
        launch = 1'b0;
        launch_idx = 5'h00;
        d.io_sync = {q.io_sync[0], link.io_line};
        tick = (q.div == DIV_LAST);
        d.div = (q.state == H_IDLE || tick) ? 8'h00 : q.div + 8'h01;

        // register port, read data in the next cycle only
        d.bus_rdata = 8'h00;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                HOST_ADDR: d.bus_rdata = {2'b00, q.addr};
                HOST_WDATA: d.bus_rdata = q.wdata;
                HOST_RDATA: d.bus_rdata = q.result;
                HOST_STATUS: d.bus_rdata = {6'h00, q.lsb, q.busy};
                default: d.bus_rdata = 8'h00;
            endcase
        end
        if (reg_wr_i && reg_addr_i == HOST_ADDR)
        begin
            d.addr = reg_wdata_i[5:0];
        end
        if (reg_wr_i && reg_addr_i == HOST_WDATA)
        begin
            d.wdata = reg_wdata_i;
        end

        unique case (q.state)
            H_IDLE:
            begin
                // a command while busy is dropped
                if (reg_wr_i && reg_addr_i == HOST_CMD)
                begin
                    d.rw = reg_wdata_i[CMD_RW_BIT];
                    d.lsb = reg_wdata_i[CMD_LSB_BIT];
                    d.seq = reg_wdata_i[CMD_LSB_BIT] ?
                        {q.wdata, 1'b0, q.addr, reg_wdata_i[CMD_RW_BIT]} :
                        rev16({reg_wdata_i[CMD_RW_BIT], q.addr, 1'b0, q.wdata});
                    d.sclk = reg_wdata_i[CMD_LSB_BIT];
                    d.busy = 1'b1;
                    d.state = H_PREP;
                end
            end
            H_PREP:
            begin
                if (tick)
                begin
                    d.cs_n = 1'b0;
                    d.rise_cnt = 5'h00;
                    launch = 1'b1;
                    d.state = H_SHIFT;
                end
            end
            H_SHIFT:
            begin
                if (tick && q.sclk)
                begin
                    // late in the high phase so the device output has settled
                    if (q.rise_cnt > CMD_LEN && q.rw)
                    begin
                        d.rx = {q.io_sync[1], q.rx[7:1]};
                    end
                    if (q.rise_cnt == XFER_LEN)
                    begin
                        d.cs_n = 1'b1;
                        d.io_oe_n = 1'b1;
                        d.sclk = q.lsb;
                        d.state = H_END;
                    end
                    else
                    begin
                        d.sclk = 1'b0;
                        launch = 1'b1;
                        launch_idx = q.rise_cnt;
                    end
                end
                else if (tick)
                begin
                    d.sclk = 1'b1;
                    d.rise_cnt = q.rise_cnt + 5'h01;
                end
            end
            H_END:
            begin
                if (tick)
                begin
                    d.result = q.lsb ? q.rx : rev8(q.rx);
                    d.busy = 1'b0;
                    d.state = H_IDLE;
                end
            end
            default:
            begin
                d.state = H_IDLE;
            end
        endcase

        if (launch)
        begin
            if (q.lsb)
            begin
                d.io_o = q.seq[launch_idx[3:0]];
                // release the shared line for the read data byte
                d.io_oe_n = !(launch_idx < CMD_LEN || !q.rw);
            end
            else
            begin
                d.din = q.seq[launch_idx[3:0]];
                d.io_oe_n = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            q <= '0;
            q.state <= H_IDLE;
            q.cs_n <= 1'b1;
            q.io_oe_n <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign link.cs_n = q.cs_n;
    assign link.sclk = q.sclk;
    assign link.in_line = q.din;
    assign link.host_io_o = q.io_o;
    assign link.host_io_oe_n = q.io_oe_n;
    assign reg_rdata_o = q.bus_rdata;
    assign busy_o = q.busy;

endmodule : scp_host
`default_nettype wire

// [test/scp_link_props.sv]
// assertions on the four-wire link between the host end and the device end
// assumes the bench feeds it the interface signals and the shared core clock
`timescale 1ns/1ns
`default_nettype none
module scp_link_props (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // link signals
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic in_line,
    input wire logic dev_io_o,
    input wire logic dev_io_oe_n,
    input wire logic host_io_o,
    input wire logic host_io_oe_n,
    input wire logic io_line
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // rising sclk edges inside the current select
    logic sclk_q;
    logic [4:0] rises_q;
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sclk_q <= 1'b0;
            rises_q <= 5'h00;
        end
        else
        begin
            sclk_q <= sclk;
            rises_q <= cs_n ? 5'h00 : rises_q + {4'h0, sclk & ~sclk_q};
        end
    end

    sequence deselected_s;
        cs_n [*5];
    endsequence
    sequence dev_launch_s;
        $fell(dev_io_oe_n) || (!dev_io_oe_n && !cs_n && $changed(dev_io_o));
    endsequence
    sequence host_launch_s;
        !cs_n && !$fell(cs_n) && ($changed(in_line) || (!host_io_oe_n && $changed(host_io_o)));
    endsequence

    a_frame_sixteen: assert property ($rose(cs_n) |-> rises_q == 5'h10)
        else $error("select closed without sixteen clocks");
    a_deselect_float: assert property (deselected_s |-> dev_io_oe_n && host_io_oe_n && io_line)
        else $error("io line driven while deselected");
    a_release_bound: assert property ($rose(cs_n) |-> ##[0:4] dev_io_oe_n)
        else $error("device kept io line after deselect");
    a_no_contention: assert property (!(!dev_io_oe_n && !host_io_oe_n))
        else $error("both ends drive io line");
    a_dev_launch_fall: assert property (dev_launch_s |-> !sclk && !cs_n && rises_q >= 5'h08)
        else $error("device output moved outside data low phase");
    a_host_launch_fall: assert property (host_launch_s |-> !sclk)
        else $error("host data moved while sclk high");
    a_half_period: assert property ((!cs_n && $changed(sclk)) |=> $stable(sclk) [*3])
        else $error("sclk phase shorter than four clocks");
    a_scheme_idle: assert property ($fell(cs_n) |-> $stable(sclk) [*2])
        else $error("sclk moved at select");
endmodule : scp_link_props
`default_nettype wire

// [test/serial_control_port_bootload_bench.sv]
// bench: host end drives the device end over one link, both schemes
// assumes design package, interface and checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module serial_control_port_bootload_bench;
    import scp_pkg::*;
    // small ram so that the overflow case stays short
    localparam int DEPTH = 16;
    logic core_clk_i;
    logic rst_n_i;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic busy;
    logic [3:0] pram_raddr;
    logic [7:0] pram_rdata;
    logic [5:0] dreg_addr;
    logic [7:0] dreg_rdata;
    logic boot_act;
    logic src_sel;
    logic [7:0] sig;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [15:0] wire_bits = 16'h0000;
    logic [15:0] wire_seen = 16'h0000;
    logic scheme_lsb = 1'b0;
    logic rd_seen = 1'b0;
    logic sclk_prev = 1'b0;
    logic [4:0] nbit = 5'h00;
    logic [7:0] sig_model;
    logic [7:0] img [DEPTH];
    logic [7:0] regs [64];
    logic [5:0] a;
    logic [7:0] d, v, p;

    scp_if i_scp_if ();
    scp_host i_scp_host (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .busy_o(busy), .link(i_scp_if.host));
    scp_device #(.PRAM_DEPTH_P(DEPTH)) i_scp_device (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .link(i_scp_if.device), .pram_raddr_i(pram_raddr), .pram_rdata_o(pram_rdata),
        .dreg_addr_i(dreg_addr), .dreg_rdata_o(dreg_rdata), .bootload_active_o(boot_act),
        .program_source_select_o(src_sel), .load_signature_o(sig));
    scp_link_props i_scp_link_props (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .cs_n(i_scp_if.cs_n), .sclk(i_scp_if.sclk), .in_line(i_scp_if.in_line),
        .dev_io_o(i_scp_if.dev_io_o), .dev_io_oe_n(i_scp_if.dev_io_oe_n),
        .host_io_o(i_scp_if.host_io_o), .host_io_oe_n(i_scp_if.host_io_oe_n),
        .io_line(i_scp_if.io_line));

    initial
    begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    // wire monitor: bits as seen at each sclk rise, on the line in use
    always @(posedge core_clk_i)
    begin
        sclk_prev <= i_scp_if.sclk;
        if (i_scp_if.cs_n)
        begin
            scheme_lsb <= i_scp_if.sclk;
            nbit <= 5'h00;
            if (nbit == 5'h10)
                wire_seen <= wire_bits;
        end
        else if (i_scp_if.sclk && !sclk_prev)
        begin
            if (nbit == 5'h01)
                rd_seen <= wire_bits[0];
            wire_bits <= {wire_bits[14:0], (scheme_lsb || (nbit[3] && rd_seen)) ?
                i_scp_if.io_line : i_scp_if.in_line};
            nbit <= nbit + 5'h01;
        end
    end

    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    function automatic logic [15:0] wire_exp(input logic rw, input logic lsb,
        input logic [5:0] aa, input logic [7:0] dd);
        logic [15:0] w;
        w = {rw, aa, 1'b0, dd};
        for (int i = 0; i < 6; i++) w[14-i] = lsb ? aa[i] : w[14-i];
        for (int i = 0; i < 8; i++) w[7-i] = lsb ? dd[i] : w[7-i];
        return w;
    endfunction : wire_exp

    function automatic logic [7:0] sig_next(input logic [7:0] s, input logic [7:0] dd);
        return {s[6:0], 1'b0} ^ (s[7] ? SIG_POLY : 8'h00) ^ dd;
    endfunction : sig_next

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic host_write(input logic [2:0] ra, input logic [7:0] rd);
        @(posedge core_clk_i);
        reg_addr <= ra;
        reg_wdata <= rd;
        reg_wr <= 1'b1;
        @(posedge core_clk_i);
        reg_wr <= 1'b0;
    endtask : host_write

    task automatic host_read(input logic [2:0] ra, output logic [7:0] rd);
        @(posedge core_clk_i);
        reg_addr <= ra;
        reg_rd <= 1'b1;
        @(posedge core_clk_i);
        reg_rd <= 1'b0;
        @(negedge core_clk_i);
        rd = reg_rdata;
    endtask : host_read

    task automatic dev_peek(input logic [5:0] ra, output logic [7:0] dr, output logic [7:0] pr);
        @(posedge core_clk_i);
        dreg_addr <= ra;
        pram_raddr <= ra[3:0];
        @(posedge core_clk_i);
        @(negedge core_clk_i);
        dr = dreg_rdata;
        pr = pram_rdata;
    endtask : dev_peek

    // one frame; for a read, dd is the byte the device must return
    task automatic frame(input logic rw, input logic lsb, input logic [5:0] aa,
        input logic [7:0] dd);
        logic [7:0] q;
        host_write(HOST_ADDR, {2'b00, aa});
        host_write(HOST_WDATA, dd);
        host_write(HOST_CMD, {6'h00, lsb, rw});
        @(negedge core_clk_i);
        check("busy", 16'(busy), 16'h0001);
        while (busy === 1'b1)
            @(negedge core_clk_i);
        check("wire", wire_seen & 16'hfeff, wire_exp(rw, lsb, aa, dd));
        host_read(HOST_STATUS, q);
        check("status", 16'(q), {14'h0, lsb, 1'b0});
        if (rw)
        begin
            host_read(HOST_RDATA, q);
            check("rdata", 16'(q), 16'(dd));
        end
    endtask : frame

    initial
    begin
        rst_n_i = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        dreg_addr = 6'h00;
        pram_raddr = 4'h0;
        for (int i = 0; i < 64; i++) regs[i] = 8'h00;
        void'($urandom(48));
        repeat (5) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        // register traffic, written in one scheme and read back in the other
        for (int i = 0; i < 10; i++)
        begin
            a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3e : 6'($urandom_range(62));
            d = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : 8'($urandom);
            regs[a] = d;
            frame(1'b0, i[0], a, d);
            dev_peek(a, v, p);
            check("dreg", 16'(v), 16'(d));
            frame(1'b1, ~i[0], a, d);
        end
        // reserved control bits are dropped
        frame(1'b0, 1'b0, BRC_ADDR, 8'hf7);
        check("mode", {14'h0, boot_act, src_sel}, 16'h0002);
        dev_peek(BRC_ADDR, v, p);
        check("dreg", 16'(v), 16'h0004);
        frame(1'b1, 1'b1, 6'h20, 8'h04);
        sig_model = SIG_SEED;
        // two fills past the ram size must be dropped
        for (int i = 0; i < DEPTH + 2; i++)
        begin
            d = 8'($urandom);
            frame(1'b0, i[1], 6'($urandom_range(15)), d);
            if (i < DEPTH)
            begin
                img[i] = d;
                sig_model = sig_next(sig_model, d);
            end
            if (i == 5)
                frame(1'b1, 1'b0, 6'h00, sig_model);
        end
        check("sig", 16'(sig), 16'(sig_model));
        for (int i = 0; i < DEPTH; i++)
        begin
            dev_peek(6'(i), v, p);
            check("pram", 16'(p), 16'(img[i]));
            check("dreg", 16'(v), 16'(regs[i]));
        end
        frame(1'b0, 1'b1, BRC_ADDR, 8'h08);
        check("mode", {14'h0, boot_act, src_sel}, 16'h0001);
        check("sig", 16'(sig), 16'h0000);
        frame(1'b0, 1'b0, BRC_ADDR, 8'h04);
        frame(1'b0, 1'b1, 6'h11, 8'h5a);
        dev_peek(6'h00, v, p);
        check("pram", 16'(p), 16'h005a);
        // hardware reset in mid-session
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(negedge core_clk_i);
        check("mode", {6'h0, boot_act, src_sel, sig}, 16'h0000);
        frame(1'b1, 1'b1, 6'h00, 8'h00);
        end_sim();
    end

    task automatic end_sim();
        if (n_mismatch == 0 && comparisons > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
endmodule : serial_control_port_bootload_bench
`default_nettype wire
